// [design/ovfr_pkg.sv]
// Package for output voltage fault response block
// What this block does
// [RULE_01] Code 00: keep regulating through fault
// [RULE_02] Code 01: wait delay, then apply retry
// [RULE_03] Delay bits 1:0 select 6.25-10 us
// [RULE_04] Unsupported codes raise invalid-data fault
// [RULE_05] Retry 000: latch off until cleared
// [RULE_06] Retry 111: hiccup restart every 1 s
// [RULE_07] Zero-volt warning: both switches off
// [RULE_08] Mode bit 2: high off, low on
// [RULE_09] UV warn limit 16 bits, reset 0067
// [RULE_10] UV warning sets status bit 6
// [RULE_11] UV fault threshold from limit bits 5:3
// [RULE_12] UV fault sets status bits, alert
// [RULE_13] Fault bits sticky until clear faults
// [RULE_14] UV response register resets to 40
// [RULE_15] Limits and responses storable to nonvolatile; code stores only limit bits 7:0, not OV bits 11:9
// [RULE_16] OV threshold bits 11:9, response 40
// [RULE_17] OV fault sets status bits, alert
// [RULE_18] Rejected write keeps old value
package ovfr_pkg;
    localparam logic [7:0] OFS_UV_WARN = 8'h43;
    localparam logic [7:0] OFS_UV_RESP = 8'h45;
    localparam logic [7:0] OFS_OV_RESP = 8'h41;
    localparam logic [7:0] OFS_MODE_CFG = 8'hC8;
    localparam logic [7:0] OFS_LIMIT_PCT = 8'hC6;
    localparam logic [7:0] OFS_STATUS_VOUT = 8'h7A;
    localparam logic [7:0] OFS_STATUS_WORD = 8'h79;
    localparam logic [15:0] RST_UV_WARN = 16'h0067;
    localparam logic [7:0] RST_RESP = 8'h40;
    localparam logic [15:0] RST_LIMIT_PCT = 16'h0000;
    localparam logic [7:0] RST_MODE_CFG = 8'h00;
    localparam int RESP_HI = 7;
    localparam int RESP_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int SV_OV_BIT = 7;
    localparam int SV_UV_WARN_BIT = 6;
    localparam int SV_UV_BIT = 4;
    localparam int SW_VOUT_BIT = 15;
    localparam int SB_OV_BIT = 5;
    localparam int MODE_LOWON_BIT = 2;
    localparam int CLK_MHZ = 10;
    localparam int DLY_NS_0 = 6250;
    localparam int DLY_NS_1 = 7500;
    localparam int DLY_NS_2 = 8750;
    localparam int DLY_NS_3 = 10000;
    localparam int HICCUP_S = 1;
    localparam int HICCUP_CYC = HICCUP_S * CLK_MHZ * 1000000;
    localparam int DLY_CYC_0 = (DLY_NS_0 * CLK_MHZ + 999) / 1000;
    localparam int DLY_CYC_1 = (DLY_NS_1 * CLK_MHZ + 999) / 1000;
    localparam int DLY_CYC_2 = (DLY_NS_2 * CLK_MHZ + 999) / 1000;
    localparam int DLY_CYC_3 = (DLY_NS_3 * CLK_MHZ + 999) / 1000;
    typedef enum logic [1:0] {OVFR_RUN, OVFR_WAIT, OVFR_OFF, OVFR_HICCUP} ovfr_state_e;
    typedef struct packed {
        logic wr;
        logic [7:0] cmd;
        logic [15:0] data;
    } ovfr_wr_s;
endpackage

// [design/ovfr_top.sv]
// Fault response logic for output over- and under-voltage
`timescale 1ns/1ps
module ovfr_top #(
    parameter int HICCUP_CYCLES = ovfr_pkg::HICCUP_CYC
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire ovfr_pkg::ovfr_wr_s reg_wr,
    input wire logic [7:0] rd_cmd,
    output logic [15:0] rd_data,
    input wire logic clear_faults,
    input wire logic store_user_all,
    input wire logic output_on_cmd,
    input wire logic ov_fault_pin,
    input wire logic uv_fault_pin,
    input wire logic uv_warn_pin,
    input wire logic zero_volt_warn_pin,
    output logic [2:0] ov_threshold_sel,
    output logic [2:0] uv_threshold_sel,
    output logic [15:0] uv_warn_threshold,
    output logic power_switch_high_en,
    output logic power_switch_low_en,
    output logic alert_out_n,
    output logic invalid_data_ff,
    output logic nvm_store_pulse,
    output logic [47:0] nvm_store_data
);
    logic ov_s1_ff, ov_s2_ff, uv_s1_ff, uv_s2_ff, wn_s1_ff, wn_s2_ff;
    logic zv_s1_ff, zv_s2_ff;
    logic [15:0] uv_warn_ff, limit_pct_ff;
    logic [7:0] uv_resp_ff, ov_resp_ff, mode_cfg_ff, status_vout_ff;
    logic status_vout_any;
    ovfr_pkg::ovfr_state_e st_ff, nxt_st;
    logic [31:0] cnt_ff, nxt_cnt;
    logic fault_ov, fault_uv, warn_uv, zero_v;
    logic [7:0] act_resp;
    logic act_fault;
    logic wr_resp, resp_bad;

    // Pin synchronisers; first stage read only by the second
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ov_s1_ff <= 1'b0;
            ov_s2_ff <= 1'b0;
            uv_s1_ff <= 1'b0;
            uv_s2_ff <= 1'b0;
            wn_s1_ff <= 1'b0;
            wn_s2_ff <= 1'b0;
            zv_s1_ff <= 1'b0;
            zv_s2_ff <= 1'b0;
        end else begin
            ov_s1_ff <= ov_fault_pin;
            ov_s2_ff <= ov_s1_ff;
            uv_s1_ff <= uv_fault_pin;
            uv_s2_ff <= uv_s1_ff;
            wn_s1_ff <= uv_warn_pin;
            wn_s2_ff <= wn_s1_ff;
            zv_s1_ff <= zero_volt_warn_pin;
            zv_s2_ff <= zv_s1_ff;
        end
    end
    assign fault_ov = ov_s2_ff;
    assign fault_uv = uv_s2_ff;
    assign warn_uv = wn_s2_ff;
    assign zero_v = zv_s2_ff;

    function automatic logic resp_invalid(input logic [7:0] v);
        logic [2:0] r;
        r = v[ovfr_pkg::RETRY_HI:ovfr_pkg::RETRY_LO];
        resp_invalid = v[ovfr_pkg::RESP_HI] || (r != 3'h0 && r != 3'h7); // [RULE_04]
    endfunction

    function automatic logic [31:0] delay_cycles(input logic [7:0] v);
        unique case (v[1:0]) // [RULE_03] [RULE_18]
            2'h0: delay_cycles = 32'(ovfr_pkg::DLY_CYC_0);
            2'h1: delay_cycles = 32'(ovfr_pkg::DLY_CYC_1);
            2'h2: delay_cycles = 32'(ovfr_pkg::DLY_CYC_2);
            2'h3: delay_cycles = 32'(ovfr_pkg::DLY_CYC_3);
        endcase
    endfunction

    assign wr_resp = reg_wr.wr && (reg_wr.cmd == ovfr_pkg::OFS_UV_RESP ||
        reg_wr.cmd == ovfr_pkg::OFS_OV_RESP);
    assign resp_bad = resp_invalid(reg_wr.data[7:0]);

    // Register writes
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            uv_warn_ff <= ovfr_pkg::RST_UV_WARN; // [RULE_09]
            uv_resp_ff <= ovfr_pkg::RST_RESP; // [RULE_14]
            ov_resp_ff <= ovfr_pkg::RST_RESP; // [RULE_16]
            limit_pct_ff <= ovfr_pkg::RST_LIMIT_PCT;
            mode_cfg_ff <= ovfr_pkg::RST_MODE_CFG;
        end else if (reg_wr.wr) begin
            if (reg_wr.cmd == ovfr_pkg::OFS_UV_WARN) begin
                uv_warn_ff <= reg_wr.data; // [RULE_09]
            end
            if (reg_wr.cmd == ovfr_pkg::OFS_UV_RESP && !resp_bad) begin
                uv_resp_ff <= reg_wr.data[7:0]; // [RULE_18]
            end
            if (reg_wr.cmd == ovfr_pkg::OFS_OV_RESP && !resp_bad) begin
                ov_resp_ff <= reg_wr.data[7:0]; // [RULE_18]
            end
            if (reg_wr.cmd == ovfr_pkg::OFS_LIMIT_PCT) begin
                limit_pct_ff <= reg_wr.data;
            end
            if (reg_wr.cmd == ovfr_pkg::OFS_MODE_CFG) begin
                mode_cfg_ff <= reg_wr.data[7:0];
            end
        end
    end
    assign ov_threshold_sel = limit_pct_ff[11:9]; // [RULE_16]
    assign uv_threshold_sel = limit_pct_ff[5:3]; // [RULE_11]
    assign uv_warn_threshold = uv_warn_ff;

    // Store snapshot; the nonvolatile array itself sits outside
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            nvm_store_pulse <= 1'b0;
            nvm_store_data <= 48'h0;
        end else begin
            nvm_store_pulse <= store_user_all; // [RULE_15]
            if (store_user_all) begin
                nvm_store_data <= {uv_warn_ff, limit_pct_ff[7:0], mode_cfg_ff,
                    uv_resp_ff, ov_resp_ff}; // [RULE_15]
            end
        end
    end

    // Sticky status; set wins over clear
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            status_vout_ff <= 8'h00;
            invalid_data_ff <= 1'b0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (clear_faults) begin
                    status_vout_ff[i] <= 1'b0; // [RULE_13]
                end
            end
            if (fault_ov) status_vout_ff[ovfr_pkg::SV_OV_BIT] <= 1'b1; // [RULE_17]
            if (fault_uv) status_vout_ff[ovfr_pkg::SV_UV_BIT] <= 1'b1; // [RULE_12]
            if (warn_uv) status_vout_ff[ovfr_pkg::SV_UV_WARN_BIT] <= 1'b1; // [RULE_10]
            if (wr_resp && resp_bad) begin
                invalid_data_ff <= 1'b1; // [RULE_04]
            end else if (clear_faults) begin
                invalid_data_ff <= 1'b0; // [RULE_13]
            end
        end
    end
    assign status_vout_any = |{status_vout_ff[ovfr_pkg::SV_OV_BIT],
        status_vout_ff[ovfr_pkg::SV_UV_BIT], status_vout_ff[ovfr_pkg::SV_UV_WARN_BIT]};
    assign alert_out_n = !(status_vout_any || invalid_data_ff); // [RULE_12] [RULE_17]

    // Read mux
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= 16'h0000;
        end else begin
            unique case (rd_cmd)
                ovfr_pkg::OFS_UV_WARN: rd_data <= uv_warn_ff;
                ovfr_pkg::OFS_UV_RESP: rd_data <= {8'h00, uv_resp_ff};
                ovfr_pkg::OFS_OV_RESP: rd_data <= {8'h00, ov_resp_ff};
                ovfr_pkg::OFS_LIMIT_PCT: rd_data <= limit_pct_ff;
                ovfr_pkg::OFS_MODE_CFG: rd_data <= {8'h00, mode_cfg_ff};
                ovfr_pkg::OFS_STATUS_VOUT: rd_data <= {8'h00, status_vout_ff};
                ovfr_pkg::OFS_STATUS_WORD: rd_data <= {status_vout_any, 9'h000,
                    status_vout_ff[ovfr_pkg::SV_OV_BIT], 5'h00}; // [RULE_12] [RULE_17]
                default: rd_data <= 16'h0000;
            endcase
        end
    end

    // OV takes precedence when both faults stand
    assign act_resp = fault_ov ? ov_resp_ff : uv_resp_ff;
    assign act_fault = fault_ov || fault_uv;

    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        unique case (st_ff)
            ovfr_pkg::OVFR_RUN: begin
                if (act_fault && act_resp[ovfr_pkg::RESP_LO]) begin
                    nxt_st = ovfr_pkg::OVFR_WAIT; // [RULE_02]
                    nxt_cnt = delay_cycles(act_resp) - 32'h1;
                end
            end
            ovfr_pkg::OVFR_WAIT: begin
                if (!act_fault || !act_resp[ovfr_pkg::RESP_LO]) begin
                    nxt_st = ovfr_pkg::OVFR_RUN; // [RULE_01]
                end else if (cnt_ff == 32'h0) begin
                    if (act_resp[ovfr_pkg::RETRY_HI:ovfr_pkg::RETRY_LO] == 3'h7) begin
                        nxt_st = ovfr_pkg::OVFR_HICCUP; // [RULE_06]
                        nxt_cnt = 32'(HICCUP_CYCLES) - 32'h1;
                    end else begin
                        nxt_st = ovfr_pkg::OVFR_OFF; // [RULE_05]
                    end
                end else begin
                    nxt_cnt = cnt_ff - 32'h1;
                end
            end
            ovfr_pkg::OVFR_OFF: begin
                if (clear_faults) nxt_st = ovfr_pkg::OVFR_RUN; // [RULE_05]
            end
            ovfr_pkg::OVFR_HICCUP: begin
                if (!output_on_cmd) begin
                    nxt_st = ovfr_pkg::OVFR_OFF; // [RULE_06]
                end else if (cnt_ff == 32'h0) begin
                    nxt_st = ovfr_pkg::OVFR_RUN; // [RULE_06]
                end else begin
                    nxt_cnt = cnt_ff - 32'h1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= ovfr_pkg::OVFR_RUN;
            cnt_ff <= 32'h0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
        end
    end

    // Power switch drive
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            power_switch_high_en <= 1'b0;
            power_switch_low_en <= 1'b0;
        end else if (zero_v) begin
            power_switch_high_en <= 1'b0; // [RULE_07]
            power_switch_low_en <= mode_cfg_ff[ovfr_pkg::MODE_LOWON_BIT]; // [RULE_08]
        end else begin
            power_switch_high_en <= output_on_cmd &&
                (st_ff == ovfr_pkg::OVFR_RUN || st_ff == ovfr_pkg::OVFR_WAIT); // [RULE_01]
            power_switch_low_en <= 1'b0;
        end
    end

    property p_sticky_uv;
        @(posedge clk_sys) disable iff (!arst_n)
        (status_vout_ff[ovfr_pkg::SV_UV_BIT] && !clear_faults) |=>
            status_vout_ff[ovfr_pkg::SV_UV_BIT];
    endproperty
    a_sticky_uv: assert property (p_sticky_uv) else $error("UV bit dropped"); // [RULE_13]

    property p_uv_alert;
        @(posedge clk_sys) disable iff (!arst_n)
        fault_uv |=> (status_vout_ff[ovfr_pkg::SV_UV_BIT] && !alert_out_n);
    endproperty
    a_uv_alert: assert property (p_uv_alert) else $error("UV fault not flagged"); // [RULE_12]

    property p_ov_alert;
        @(posedge clk_sys) disable iff (!arst_n)
        fault_ov |=> (status_vout_ff[ovfr_pkg::SV_OV_BIT] && !alert_out_n);
    endproperty
    a_ov_alert: assert property (p_ov_alert) else $error("OV fault not flagged"); // [RULE_17]

    property p_warn;
        @(posedge clk_sys) disable iff (!arst_n)
        warn_uv |=> status_vout_ff[ovfr_pkg::SV_UV_WARN_BIT];
    endproperty
    a_warn: assert property (p_warn) else $error("UV warn not flagged"); // [RULE_10]

    property p_bad_write;
        @(posedge clk_sys) disable iff (!arst_n)
        (wr_resp && resp_bad && reg_wr.cmd == ovfr_pkg::OFS_UV_RESP) |=>
            (invalid_data_ff && uv_resp_ff == $past(uv_resp_ff));
    endproperty
    a_bad_write: assert property (p_bad_write) else $error("Bad write accepted"); // [RULE_04]

    property p_ignore;
        @(posedge clk_sys) disable iff (!arst_n)
        (st_ff == ovfr_pkg::OVFR_RUN && act_resp[7:6] == 2'h0) |=> st_ff == ovfr_pkg::OVFR_RUN;
    endproperty
    a_ignore: assert property (p_ignore) else $error("Ignore mode left run"); // [RULE_01]

    property p_zero_v;
        @(posedge clk_sys) disable iff (!arst_n)
        zero_v |=> (!power_switch_high_en &&
            power_switch_low_en == $past(mode_cfg_ff[ovfr_pkg::MODE_LOWON_BIT]));
    endproperty
    a_zero_v: assert property (p_zero_v) else $error("Zero volt drive wrong"); // [RULE_07]

    property p_latch;
        @(posedge clk_sys) disable iff (!arst_n)
        (st_ff == ovfr_pkg::OVFR_OFF && !clear_faults) |=> st_ff == ovfr_pkg::OVFR_OFF;
    endproperty
    a_latch: assert property (p_latch) else $error("Latch off restarted"); // [RULE_05]

    property p_off_drive;
        @(posedge clk_sys) disable iff (!arst_n)
        (st_ff == ovfr_pkg::OVFR_OFF) |=> !power_switch_high_en;
    endproperty
    a_off_drive: assert property (p_off_drive) else $error("Output on while off"); // [RULE_05]

    property p_ov_bad_write;
        @(posedge clk_sys) disable iff (!arst_n)
        (wr_resp && resp_bad && reg_wr.cmd == ovfr_pkg::OFS_OV_RESP) |=>
            (invalid_data_ff && ov_resp_ff == $past(ov_resp_ff));
    endproperty
    a_ov_bad_write: assert property (p_ov_bad_write) else $error("OV write taken"); // [RULE_18]

    property p_hiccup_hold;
        @(posedge clk_sys) disable iff (!arst_n)
        (st_ff == ovfr_pkg::OVFR_HICCUP && output_on_cmd && cnt_ff != 32'h0) |=>
            st_ff == ovfr_pkg::OVFR_HICCUP;
    endproperty
    a_hiccup_hold: assert property (p_hiccup_hold) else $error("Hiccup too short"); // [RULE_06]
endmodule

// [sim/ovfr_host.sv]
// Host side model: command writes, reads and store requests
`timescale 1ns/1ps
module ovfr_host (
    input wire logic clk_sys,
    output ovfr_pkg::ovfr_wr_s reg_wr,
    output logic [7:0] rd_cmd,
    output logic rd_go,
    output logic store_user_all
);
    initial begin
        reg_wr = '0;
        rd_cmd = 8'h00;
        rd_go = 1'b0;
        store_user_all = 1'b0;
    end
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(posedge clk_sys);
        #1;
        reg_wr = '{wr: 1'b1, cmd: c, data: d};
        @(posedge clk_sys);
        #1;
        // Stale data must not look valid after the strobe
        reg_wr = '{wr: 1'b0, cmd: c, data: ~d};
    endtask
    task automatic rd(input logic [7:0] c);
        @(posedge clk_sys);
        #1;
        rd_cmd = c;
        rd_go = 1'b1;
        @(posedge clk_sys);
        #1;
        rd_go = 1'b0;
    endtask
    task automatic store();
        @(posedge clk_sys);
        #1;
        store_user_all = 1'b1;
        @(posedge clk_sys);
        #1;
        store_user_all = 1'b0;
    endtask
endmodule

// [sim/tb_ovfr_top.sv]
// Self-checking bench for the voltage fault response block
`timescale 1ns/1ps
module tb_ovfr_top;
    localparam int HIC = 20;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic clear_faults = 1'b0;
    logic output_on_cmd = 1'b0;
    logic ov_fault_pin = 1'b0;
    logic uv_fault_pin = 1'b0;
    logic uv_warn_pin = 1'b0;
    logic zero_volt_warn_pin = 1'b0;
    ovfr_pkg::ovfr_wr_s reg_wr;
    logic [7:0] rd_cmd;
    logic rd_go, store_user_all, hi_en, lo_en, alert_out_n, inval, nvm_pulse;
    logic [15:0] rd_data, uv_thr, warn, lim;
    logic [2:0] ov_sel, uv_sel;
    logic [47:0] nvm_data;
    logic [31:0] exp_q[$];
    logic [31:0] note;
    logic [7:0] uvr, mode, d8, ofs;
    int dly[4] = '{ovfr_pkg::DLY_CYC_0, ovfr_pkg::DLY_CYC_1, ovfr_pkg::DLY_CYC_2,
                   ovfr_pkg::DLY_CYC_3};
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;
    ovfr_host h (.clk_sys(clk_sys), .reg_wr(reg_wr), .rd_cmd(rd_cmd), .rd_go(rd_go),
                 .store_user_all(store_user_all));
    ovfr_top #(.HICCUP_CYCLES(HIC)) dut (.clk_sys(clk_sys), .arst_n(arst_n),
        .reg_wr(reg_wr), .rd_cmd(rd_cmd), .rd_data(rd_data), .clear_faults(clear_faults),
        .store_user_all(store_user_all), .output_on_cmd(output_on_cmd),
        .ov_fault_pin(ov_fault_pin), .uv_fault_pin(uv_fault_pin), .uv_warn_pin(uv_warn_pin),
        .zero_volt_warn_pin(zero_volt_warn_pin), .ov_threshold_sel(ov_sel),
        .uv_threshold_sel(uv_sel), .uv_warn_threshold(uv_thr), .power_switch_high_en(hi_en),
        .power_switch_low_en(lo_en), .alert_out_n(alert_out_n), .invalid_data_ff(inval),
        .nvm_store_pulse(nvm_pulse), .nvm_store_data(nvm_data));
    initial forever #50 clk_sys = ~clk_sys;
    task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] x);
        checked++;
        if (seen !== x) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Read result lands one cycle after the command; mask keeps only the bits noted
    always @(posedge clk_sys) begin
        if (rd_go === 1'b1) begin
            #1;
            note = exp_q.pop_front();
            check("rd_data", rd_data & note[31:16], note[15:0]);
        end
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic rd_note(input logic [7:0] c, input logic [15:0] m, input logic [15:0] x);
        exp_q.push_back({m, x});
        h.rd(c);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task automatic clr();
        cyc(1);
        clear_faults = 1'b1;
        cyc(1);
        clear_faults = 1'b0;
    endtask
    initial begin
        void'($urandom(96));
        cyc(16);
        arst_n = 1'b1;
        output_on_cmd = 1'b1;
        check("uv_thr", uv_thr, 16'h0067);
        rd_note(ovfr_pkg::OFS_UV_WARN, 16'hFFFF, 16'h0067);
        rd_note(ovfr_pkg::OFS_UV_RESP, 16'h00FF, 16'h0040);
        rd_note(ovfr_pkg::OFS_OV_RESP, 16'h00FF, 16'h0040);
        for (int i = 0; i < 8; i++) begin
            d8 = (i == 0) ? 8'h80 : (i == 1) ? 8'hC0 : 8'h40 | 8'((i - 1) << 3);
            ofs = i[0] ? ovfr_pkg::OFS_OV_RESP : ovfr_pkg::OFS_UV_RESP;
            h.wr(ofs, {8'h00, d8});
            cyc(1);
            check("invalid", inval, 1'b1);
            check("alert", alert_out_n, 1'b0);
            rd_note(ofs, 16'h00FF, 16'h0040);
            clr();
            cyc(1);
            check("invalid", inval, 1'b0);
        end
        warn = 16'($urandom);
        lim = 16'($urandom);
        h.wr(ovfr_pkg::OFS_UV_WARN, warn);
        h.wr(ovfr_pkg::OFS_LIMIT_PCT, lim);
        cyc(1);
        check("uv_thr", uv_thr, warn);
        check("uv_sel", uv_sel, lim[5:3]);
        check("ov_sel", ov_sel, lim[11:9]);
        rd_note(ovfr_pkg::OFS_UV_WARN, 16'hFFFF, warn);
        h.wr(ovfr_pkg::OFS_UV_RESP, 16'h0000);
        uv_fault_pin = 1'b1;
        cyc(120);
        check("high_en", hi_en, 1'b1);
        check("alert", alert_out_n, 1'b0);
        uv_fault_pin = 1'b0;
        cyc(5);
        rd_note(ovfr_pkg::OFS_STATUS_VOUT, 16'h0010, 16'h0010);
        rd_note(ovfr_pkg::OFS_STATUS_WORD, 16'h8000, 16'h8000);
        check("alert", alert_out_n, 1'b0);
        clr();
        cyc(1);
        check("alert", alert_out_n, 1'b1);
        for (int d = 0; d < 4; d++) begin
            uvr = 8'h40 | 8'(d) | (8'($urandom) & 8'h04);
            h.wr(ovfr_pkg::OFS_UV_RESP, {8'h00, uvr});
            uv_fault_pin = 1'b1;
            // Two sync flops, the state step and the drive flop add four cycles
            cyc(dly[d] + 3);
            check("high_en", hi_en, 1'b1);
            cyc(1);
            check("high_en", hi_en, 1'b0);
            uv_fault_pin = 1'b0;
            cyc(30);
            check("high_en", hi_en, 1'b0);
            clr();
            cyc(4);
            check("high_en", hi_en, 1'b1);
        end
        uvr = 8'h78;
        h.wr(ovfr_pkg::OFS_UV_RESP, {8'h00, uvr});
        uv_fault_pin = 1'b1;
        cyc(dly[0] + 8);
        check("high_en", hi_en, 1'b0);
        uv_fault_pin = 1'b0;
        cyc(HIC - 5);
        check("high_en", hi_en, 1'b0);
        cyc(1);
        check("high_en", hi_en, 1'b1);
        output_on_cmd = 1'b0;
        cyc(4);
        check("high_en", hi_en, 1'b0);
        output_on_cmd = 1'b1;
        clr();
        ov_fault_pin = 1'b1;
        cyc(5);
        check("alert", alert_out_n, 1'b0);
        rd_note(ovfr_pkg::OFS_STATUS_VOUT, 16'h0080, 16'h0080);
        rd_note(ovfr_pkg::OFS_STATUS_WORD, 16'h8020, 16'h8020);
        ov_fault_pin = 1'b0;
        uv_warn_pin = 1'b1;
        cyc(5);
        rd_note(ovfr_pkg::OFS_STATUS_VOUT, 16'h0040, 16'h0040);
        uv_warn_pin = 1'b0;
        clr();
        zero_volt_warn_pin = 1'b1;
        cyc(5);
        check("high_en", hi_en, 1'b0);
        check("low_en", lo_en, 1'b0);
        zero_volt_warn_pin = 1'b0;
        mode = 8'h04;
        h.wr(ovfr_pkg::OFS_MODE_CFG, {8'h00, mode});
        clr();
        zero_volt_warn_pin = 1'b1;
        cyc(5);
        check("high_en", hi_en, 1'b0);
        check("low_en", lo_en, 1'b1);
        zero_volt_warn_pin = 1'b0;
        clr();
        h.store();
        for (int k = 0; k < 3 && nvm_pulse !== 1'b1; k++) cyc(1);
        check("nvm_pulse", nvm_pulse, 1'b1);
        check("nvm_data", nvm_data, {warn, lim[7:0], mode, uvr, 8'h40});
        stop_test();
    end
endmodule
